// ---- src/rcl_timer_regs.vh ----
// Constants for the RC level-duration timer
// Assumes inclusion by src files of the rcl block only
`ifndef RCL_TIMER_REGS_VH
`define RCL_TIMER_REGS_VH
`define RCL_UNIT_CYCLES 6'd40
`define RCL_UNIT_LAST 6'd39
`define RCL_CNT_MAX 16'hffff
`define RCL_CNT_ONE 16'h0001
`define RCL_CNT_ZERO 16'h0000
`define RCL_PRE_ZERO 6'h00
`endif

// ---- src/rcl_prescaler.v ----
// Timing-unit prescaler: pulses once every 40 oscillator cycles
// Assumes clk is the running oscillator; restart aligns it to a measurement start
`include "rcl_timer_regs.vh"
`default_nettype none
module rcl_prescaler (
    input wire clk,
    input wire rstSync_n,
    input wire restart,
    output reg unitTick
);
    reg [5:0] preCnt_r;

    always @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            preCnt_r <= `RCL_PRE_ZERO;
            unitTick <= 1'b0;
        end
        else if (restart)
        begin
            preCnt_r <= `RCL_PRE_ZERO;
            unitTick <= 1'b0;
        end
        else if (preCnt_r == `RCL_UNIT_LAST)
        begin
            preCnt_r <= `RCL_PRE_ZERO;
            unitTick <= 1'b1;
        end
        else
        begin
            preCnt_r <= preCnt_r + 6'h01;
            unitTick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- src/rcl_timer.v ----
// RC level-duration timer: counts timing units while a pin holds a level
// Assumes pinIn is synchronous to clk and the caller precharged the capacitor
// Operation
// - On start the pin becomes an input and stays one afterward.
// - Count timing units while the sampled pin equals the target level.
// - Target level bit: 1 is high, 0 is low.
// - One unit is 10us at 4 MHz and 2us at 20 MHz.
// - Unit follows the real oscillator; no crystal setting affects it.
// - Stop in the first unit the pin no longer matches; report count.
// - Pin not at level at start returns 1.
// - Level held beyond 65535 units ends measurement and returns 0.
`include "rcl_timer_regs.vh"
`default_nettype none
module rcl_timer (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire targetLevel,
    input wire pinIn,
    output reg pinOutEn,
    output reg busy,
    output reg done,
    output reg [15:0] result
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    reg rstMeta_r;
    reg rstSync_r;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg level_r;
    reg [15:0] count_r;
    reg [15:0] count_nxt;
    reg [15:0] result_nxt;
    reg done_nxt;
    reg level_nxt;
    wire unitTick;
    wire accept;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One more timing unit
    function [15:0] unitInc;
        input [15:0] cnt;
        begin
            unitInc = cnt + `RCL_CNT_ONE;
        end
    endfunction

    function levelLost;
        input pin;
        input level;
        begin
            levelLost = (pin != level);
        end
    endfunction

    // Last count that still fits the result
    function atLimit;
        input [15:0] cnt;
        begin
            atLimit = (cnt == `RCL_CNT_MAX);
        end
    endfunction

    function isState;
        input [1:0] cur;
        input [1:0] want;
        begin
            isState = (cur == want);
        end
    endfunction

    // ------------------------------------------------------------
    // Unit prescaler
    // ------------------------------------------------------------
    assign accept = start && isState(state_r, ST_IDLE);

    rcl_prescaler uPre (
        .clk(clk),
        .rstSync_n(rstSync_r),
        .restart(accept),
        .unitTick(unitTick)
    );

    // ------------------------------------------------------------
    // Measurement control
    // ------------------------------------------------------------
    always @*
    begin
        state_nxt = state_r;
        count_nxt = count_r;
        result_nxt = result;
        done_nxt = 1'b0;
        level_nxt = level_r;
        case (state_r)
            ST_IDLE:
            begin
                if (accept)
                begin
                    level_nxt = targetLevel;
                    count_nxt = `RCL_CNT_ZERO;
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (unitTick)
                begin
                    if (levelLost(pinIn, level_r))
                    begin
                        // The unit that sees the change is counted, so a miss at start gives 1
                        if (atLimit(count_r))
                        begin
                            // A span of 65536 units does not fit and reads as a timeout
                            result_nxt = `RCL_CNT_ZERO;
                        end
                        else
                        begin
                            result_nxt = unitInc(count_r);
                        end
                        done_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end
                    else if (atLimit(count_r))
                    begin
                        result_nxt = `RCL_CNT_ZERO;
                        done_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end
                    else
                    begin
                        count_nxt = unitInc(count_r);
                    end
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            state_r <= ST_IDLE;
            count_r <= `RCL_CNT_ZERO;
            level_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            level_r <= level_nxt;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            result <= `RCL_CNT_ZERO;
            done <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            result <= result_nxt;
            done <= done_nxt;
            busy <= isState(state_nxt, ST_RUN);
        end
    end

    // ------------------------------------------------------------
    // Pin direction
    // ------------------------------------------------------------
    // Never driven: the pin stays an input before, during and after a measurement
    always @(posedge clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            pinOutEn <= 1'b0;
        end
        else
        begin
            pinOutEn <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- tb/rcl_timer_props.sv ----
// Port checks for rcl_timer
// Assumes a bind from the bench
`default_nettype none
module rcl_timer_props(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic targetLevel,
    input wire logic pinIn,
    input wire logic pinOutEn,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] result
);
    timeunit 1ns;
    timeprecision 1ns;
    int len_r;
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            len_r <= 0;
        else
            len_r <= busy ? len_r + 1 : 0;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_PIN_IN: assert property (!pinOutEn) else $error("pin driven");
    AST_TAKE: assert property (start && !busy |=> busy) else $error("no start");
    AST_UNIT: assert property ($rose(busy) |-> ##40 busy) else $error("short unit");
    AST_PULSE: assert property (done |=> !done) else $error("long done");
    AST_END: assert property ($fell(busy) |-> done) else $error("busy fell");
    AST_HOLD: assert property (!done |-> $stable(result)) else $error("result moved");
    AST_ONE: assert property (done && !$past(busy, 42) |-> result == 16'h0001)
        else $error("first unit");
    AST_LEN: assert property (done |-> len_r == 40 * result + 1 || result == 16'h0000)
        else $error("length");
    cover property (done && result == 16'h0001);
    cover property (done && result > 16'h0001);
    cover property (start && busy);
endmodule
`default_nettype wire

// ---- tb/rcl_rc_net.sv ----
// RC network on the measured pin
// Assumes go marks an accepted start
`default_nettype none
module rcl_rc_net(
    input wire logic clk,
    input wire logic go,
    input wire logic lvl,
    input wire logic [15:0] dur,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    logic l = 1'b0;
    always @(posedge clk)
        cnt <= go ? 0 : cnt + 1;
    always @(posedge clk)
        if (go)
            l <= lvl;
    assign pin = (cnt < dur) ? l : ~l;
endmodule
`default_nettype wire

// ---- tb/rcl_timer_tb.sv ----
// Bench for rcl_timer
// Assumes the design files are compiled first
`default_nettype none
module rcl_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, lvl = 1'b0, pinIn, pinOutEn, busy, done;
    logic [15:0] result, dur = 16'h0000;
    int error_cnt = 0, n_compared = 0, n;
    int expQ[$];
    always #5 clk = ~clk;
    rcl_timer i_rcl_timer(.clk(clk), .rst_n(rst_n), .start(start), .targetLevel(lvl),
        .pinIn(pinIn), .pinOutEn(pinOutEn), .busy(busy), .done(done), .result(result));
    rcl_rc_net i_rcl_rc_net(.clk(clk), .go(start && !busy), .lvl(lvl), .dur(dur), .pin(pinIn));
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic complete_run;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'he90f331d));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            n = (i == 0) ? 0 : $urandom % 12;
            lvl <= i[0];
            dur <= 16'(40 * n + 20);
            start <= 1'b1;
            expQ.push_back(n + 1);
            @(posedge clk);
            lvl <= ~lvl;
            @(posedge clk);
            start <= 1'b0;
            for (int k = 0; k < 1000 && done !== 1'b1; k++) @(negedge clk);
            check("done", 16'h0001, {15'h0000, done});
            check("result", 16'(expQ.pop_front()), result);
            check("busy", 16'h0000, {15'h0000, busy});
            check("pinOutEn", 16'h0000, {15'h0000, pinOutEn});
            @(posedge clk);
        end
        complete_run;
    end
    initial
    begin
        #100000;
        error_cnt++;
        complete_run;
    end
endmodule
bind rcl_timer rcl_timer_props i_props(.clk(clk), .rst_n(rst_n), .start(start),
    .targetLevel(targetLevel), .pinIn(pinIn), .pinOutEn(pinOutEn), .busy(busy), .done(done),
    .result(result));
`default_nettype wire
